/* plbb_pkg.sv */
// Purpose: Constants for the host-to-local bus bridge.
// Assumes: 200 MHz system clock, local clock derived by a divider.
// Notes:   Field positions follow the bridge control word.
package plbb_pkg;
  localparam int          ADDR_W        = 20;
  localparam int          DATA_W        = 16;
  localparam int          CTRL_W        = 16;
  localparam int          CLK_MHZ       = 200;
  localparam int          LOCAL_CLK_DIV = 3;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam int          CTRL_CLKE_BIT = 0;
  localparam int          CTRL_ARB_BIT  = 1;
  localparam int          CTRL_LEN_LSB  = 2;
  localparam int          CTRL_WIDE_BIT = 6;
  localparam int          CTRL_SEIZE_LSB = 8;
  localparam logic [4:0]  SEIZE_BASE_LOG2 = 5'h05;
  localparam logic [3:0]  LEN_MAX       = 4'hB;
  localparam logic [20:0] SEIZE_MARGIN  = 21'h000010;
  localparam logic [3:0]  READY_WAIT_LOCAL_CLKS = 4'h9;
  localparam logic [3:0]  BE_B0   = 4'hE;
  localparam logic [3:0]  BE_B1   = 4'hD;
  localparam logic [3:0]  BE_B2   = 4'hB;
  localparam logic [3:0]  BE_B3   = 4'h7;
  localparam logic [3:0]  BE_LO16 = 4'hC;
  localparam logic [3:0]  BE_HI16 = 4'h3;
  localparam logic [3:0]  BE_NONE = 4'hF;
endpackage : plbb_pkg

/* plbb_clkdiv.sv */
// Purpose: Local bus clock divider with edge strobes.
// Assumes: Runs on the system clock.
// Notes:   Rise/fall strobes align local state changes to the output clock.
`timescale 1ns/1ps
`default_nettype none
module plbb_clkdiv (
  // System
  input  wire logic clk,
  input  wire logic srst,
  // Local clock
  output logic      bus_clk,
  output logic      rise,
  output logic      fall
);
  logic [1:0] cnt;
  wire        wrap = (cnt == 2'(plbb_pkg::LOCAL_CLK_DIV - 1));

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt     <= 2'h0;
      bus_clk <= 1'b0;
    end else begin
      cnt     <= wrap ? 2'h0 : cnt + 2'h1;
      if (wrap) begin
        bus_clk <= ~bus_clk;
      end
    end
  end

  assign rise = wrap & ~bus_clk;
  assign fall = wrap & bus_clk;
endmodule : plbb_clkdiv
`default_nettype wire

/* plbb_bridge.sv */
// Purpose: Host access bridge onto a non-multiplexed 20-bit local bus.
// Assumes: Host request is a pulse; answer is done/abort/retry pulse.
// Notes:   Straps and local ready/irq/grant inputs pass two flops before use.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module plbb_bridge (
  // System
  input  wire logic        clk,
  input  wire logic        srst,
  // Straps
  input  wire logic        bus_role_select,
  input  wire logic        strobe_style_select,
  // Control word and status
  input  wire logic [15:0] bridge_control_reg,
  input  wire logic        local_bus_error_clear,
  output logic             local_bus_error_flag,
  input  wire logic        local_interrupt_clear,
  output logic             local_interrupt_flag,
  // Host access
  input  wire logic        host_req,
  input  wire logic        host_write,
  input  wire logic [19:0] host_addr,
  input  wire logic [31:0] host_wdata,
  input  wire logic [3:0]  pci_byte_enables_n,
  output logic             host_done,
  output logic             host_abort,
  output logic             host_retry,
  output logic [31:0]      host_rdata,
  // Local bus
  output logic [19:0]      local_address_lines,
  output logic             local_address_oe,
  input  wire logic [15:0] local_data_in,
  output logic [15:0]      local_data_out,
  output logic             local_data_oe,
  output logic             write_strobe_n,
  output logic             read_strobe_n,
  output logic             strobe_oe,
  output logic             upper_byte_enable_n,
  output logic             upper_byte_oe,
  output logic             local_bus_clock_out,
  output logic             local_clock_oe,
  output logic             hold_request,
  output logic             hold_oe,
  output logic             bus_ownership_ack_n,
  output logic             ownership_oe,
  input  wire logic        local_ready_n,
  input  wire logic        hold_grant,
  input  wire logic        local_irq_n_in,
  output logic             local_irq_n_out,
  output logic             local_irq_oe,
  input  wire logic        local_select_n
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_XFER  = 2'b10
  } plbb_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [4:0] sy1, sy2;
  always_ff @(posedge clk) begin
    if (srst) begin
      sy1 <= 5'h1D;
      sy2 <= 5'h1D;
    end else begin
      sy1 <= {local_ready_n, local_irq_n_in, hold_grant,
              strobe_style_select, bus_role_select};
      sy2 <= sy1;
    end
  end
  wire cfg_role  = sy2[0];
  wire rwds      = sy2[1];
  wire grant_raw = sy2[2];
  wire irq_n     = sy2[3];
  wire rdy_n     = sy2[4];
  // Grant is active low in the request/grant style
  wire granted   = rwds ? ~grant_raw : grant_raw;

  ////////////////////////////////////////////////////////////////////////////
  // Local clock
  wire div_clk, lrise, lfall;
  plbb_clkdiv u_div (
    .clk     (clk),
    .srst    (srst),
    .bus_clk (div_clk),
    .rise (lrise),
    .fall (lfall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control decode
  wire       clk_en   = bridge_control_reg[plbb_pkg::CTRL_CLKE_BIT];
  wire       arb_en   = bridge_control_reg[plbb_pkg::CTRL_ARB_BIT];
  wire [3:0] len      = bridge_control_reg[plbb_pkg::CTRL_LEN_LSB +: 4];
  wire       narrow   = bridge_control_reg[plbb_pkg::CTRL_WIDE_BIT];
  wire [3:0] seize    = bridge_control_reg[plbb_pkg::CTRL_SEIZE_LSB +: 4];
  wire       arb_on   = arb_en & ~cfg_role;

  ////////////////////////////////////////////////////////////////////////////
  // Byte enable mapping
  wire [3:0] be = pci_byte_enables_n;
  wire is_b0  = (be == plbb_pkg::BE_B0);
  wire is_b1  = (be == plbb_pkg::BE_B1);
  wire is_b2  = (be == plbb_pkg::BE_B2);
  wire is_b3  = (be == plbb_pkg::BE_B3);
  wire is_h0  = (be == plbb_pkg::BE_LO16);
  wire is_h1  = (be == plbb_pkg::BE_HI16);
  wire be_none = (be == plbb_pkg::BE_NONE);
  wire single  = is_b0 | is_b1 | is_b2 | is_b3;
  wire be_ok   = narrow ? single : (single | is_h0 | is_h1);
  wire [1:0] a_lo = {is_b2 | is_b3 | is_h1, is_b1 | is_b3};
  wire hi_lane = ~narrow & (is_b1 | is_b3);
  wire word16  = ~narrow & (is_h0 | is_h1);
  wire ube_n   = ~(hi_lane | word16);
  wire [15:0] wsel =
      word16 ? (is_h1 ? host_wdata[31:16] : host_wdata[15:0]) :
      (is_b0 ? {2{host_wdata[7:0]}}   :
       is_b1 ? {2{host_wdata[15:8]}}  :
       is_b2 ? {2{host_wdata[23:16]}} : {2{host_wdata[31:24]}});
  wire [15:0] wdata = narrow ? {8'h00, wsel[7:0]} : wsel;

  ////////////////////////////////////////////////////////////////////////////
  // Seize timer, counted in local clocks
  logic [20:0] seize_left;
  logic        owned;
  logic        want_bus;
  wire  [20:0] seize_load = 21'(21'h1 << (plbb_pkg::SEIZE_BASE_LOG2
                                          + 5'(seize)));
  wire         room = seize_left >= plbb_pkg::SEIZE_MARGIN;
  wire         bus_ok = ~arb_on | (owned & room);

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state
  plbb_state_e st, next_st;
  logic [3:0]  lcnt;
  logic        wr;
  logic [15:0] wd;
  logic [19:0] ad;
  logic        ube;
  logic        wide_rd, hi_rd;
  logic [1:0]  byte_idx;

  wire accept   = host_req & (st == ST_IDLE) & ~cfg_role;
  wire go       = accept & ~be_none & be_ok & bus_ok;
  wire do_abort = accept & ~be_none & ~be_ok;
  wire do_retry = accept & ~be_none & be_ok & ~bus_ok;
  wire fixed    = (len != 4'h0) & (len <= plbb_pkg::LEN_MAX);
  wire xfer_end = (st == ST_XFER) & lrise & (fixed ?
                    (lcnt >= len - 4'h1) : ~rdy_n);
  wire timeout  = (st == ST_XFER) & lrise & ~fixed & rdy_n &
                  (lcnt >= plbb_pkg::READY_WAIT_LOCAL_CLKS - 4'h1);

  always_comb begin
    next_st = st;
    case (st)
      ST_IDLE:  next_st = go ? ST_SETUP : ST_IDLE;
      ST_SETUP: next_st = lfall ? ST_XFER : ST_SETUP;
      ST_XFER:  next_st = (xfer_end | timeout) ? ST_IDLE : ST_XFER;
      default:  next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= ST_IDLE;
      lcnt <= 4'h0;
    end else begin
      st <= next_st;
      if (st != ST_XFER) begin
        lcnt <= 4'h0;
      end else if (lrise && lcnt != 4'hF) begin
        lcnt <= lcnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr <= 1'b0;
      wd <= 16'h0000;
      ad <= 20'h00000;
      ube <= 1'b1;
      wide_rd <= 1'b0;
      hi_rd <= 1'b0;
      byte_idx <= 2'h0;
    end else if (go) begin
      wr <= host_write;
      wd <= wdata;
      ad <= {host_addr[19:2], a_lo};
      ube <= ube_n;
      wide_rd <= word16;
      hi_rd <= hi_lane;
      byte_idx <= a_lo;
    end
  end

  // Arbitration: request follows a refused access while the bus is not owned
  always_ff @(posedge clk) begin
    if (srst || !arb_on) begin
      want_bus <= 1'b0;
      owned <= 1'b0;
      seize_left <= 21'h000000;
    end else begin
      if (do_retry && !owned) begin
        want_bus <= 1'b1;
      end else if (owned) begin
        want_bus <= 1'b0;
      end
      if (!owned && want_bus && granted && lrise) begin
        owned <= 1'b1;
        seize_left <= seize_load;
      end else if (owned && lrise && st == ST_IDLE
                   && seize_left <= 21'h000001) begin
        owned <= 1'b0;
        seize_left <= 21'h000000;
      end else if (owned && lrise && seize_left != 21'h000000) begin
        seize_left <= seize_left - 21'h000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host answers and read data
  logic [15:0] rlane;
  always_ff @(posedge clk) begin
    if (srst) begin
      host_done  <= 1'b0;
      host_abort <= 1'b0;
      host_retry <= 1'b0;
      host_rdata <= 32'h00000000;
    end else begin
      host_done  <= xfer_end;
      host_abort <= do_abort;
      host_retry <= do_retry | timeout;
      if (xfer_end && !wr) begin
        host_rdata <= {2{rlane}};
      end
    end
  end
  always_comb begin
    rlane = local_data_in;
    if (!wide_rd) begin
      rlane = hi_rd ? {2{local_data_in[15:8]}} : {2{local_data_in[7:0]}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: set wins over clear
  logic irq_prev;
  always_ff @(posedge clk) begin
    if (srst) begin
      local_bus_error_flag <= 1'b0;
      local_interrupt_flag <= 1'b0;
      irq_prev <= 1'b1;
    end else begin
      irq_prev <= irq_n;
      if (timeout) begin
        local_bus_error_flag <= 1'b1;
      end else if (local_bus_error_clear) begin
        local_bus_error_flag <= 1'b0;
      end
      if (!cfg_role && !irq_n && irq_prev) begin
        local_interrupt_flag <= 1'b1;
      end else if (local_interrupt_clear) begin
        local_interrupt_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  wire busy   = (st != ST_IDLE);
  wire strobe = (st == ST_XFER);
  wire master = ~cfg_role & (~arb_on | owned);
  assign local_address_lines = ad;
  assign local_address_oe    = master;
  assign local_data_out      = wd;
  assign local_data_oe       = master & busy & wr;
  assign upper_byte_enable_n = ube;
  assign upper_byte_oe       = master;
  assign strobe_oe           = master;
  // Separate strobes, or write-low select plus data strobe
  assign write_strobe_n = rwds ? ~(busy & wr) : ~(strobe & wr);
  assign read_strobe_n  = rwds ? ~strobe : ~(strobe & ~wr);
  assign local_bus_clock_out = div_clk;
  assign local_clock_oe      = ~cfg_role & clk_en;
  assign hold_request        = rwds ? ~want_bus : want_bus;
  assign hold_oe             = ~cfg_role & arb_on;
  assign bus_ownership_ack_n = ~owned;
  assign ownership_oe        = ~cfg_role & arb_on;
  // Configuration role: irq is an output; select is for the slave port
  assign local_irq_n_out     = local_select_n | 1'b1;
  assign local_irq_oe        = cfg_role;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_cfg_block;
    @(posedge clk) disable iff (srst)
    cfg_role |-> ##1 (!host_done && !host_abort && !host_retry);
  endproperty
  a_cfg_block: assert property (p_cfg_block) else $error("cfg access");

  property p_no_be;
    @(posedge clk) disable iff (srst)
    (accept && be_none) |-> ##1 (!host_abort && st == ST_IDLE);
  endproperty
  a_no_be: assert property (p_no_be) else $error("empty be acted");

  property p_abort;
    @(posedge clk) disable iff (srst)
    do_abort |-> ##1 (host_abort && st == ST_IDLE);
  endproperty
  a_abort: assert property (p_abort) else $error("abort missing");

  property p_retry_float;
    @(posedge clk) disable iff (srst)
    do_retry |-> (!local_address_oe || owned) ##1 host_retry;
  endproperty
  a_retry_float: assert property (p_retry_float) else $error("retry bad");

  property p_arb_off;
    @(posedge clk) disable iff (srst)
    !arb_en |-> ##1 !owned;
  endproperty
  a_arb_off: assert property (p_arb_off) else $error("arb active");

  property p_room;
    @(posedge clk) disable iff (srst)
    (go && arb_on) |-> (owned && seize_left >= 21'h000010);
  endproperty
  a_room: assert property (p_room) else $error("seize margin");

  property p_timeout_flag;
    @(posedge clk) disable iff (srst)
    timeout |-> ##1 (local_bus_error_flag && host_retry);
  endproperty
  a_timeout_flag: assert property (p_timeout_flag) else $error("tmo");

  property p_narrow_lane;
    @(posedge clk) disable iff (srst)
    (go && narrow) |-> ##1 (upper_byte_enable_n && wd[15:8] == 8'h00);
  endproperty
  a_narrow_lane: assert property (p_narrow_lane) else $error("lane");
endmodule : plbb_bridge
`default_nettype wire

/* plbb_local_model.sv */
// Purpose: Local bus partner: peripheral port and hold/grant arbiter.
// Assumes: Hold request active high; either strobe style.
// Notes:   Captures the last local cycle for the bench to judge.
`timescale 1ns/1ps
`default_nettype none
module plbb_local_model (
  // System
  input  wire logic        clk,
  // Bridge outputs
  input  wire logic        local_bus_clock_out,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        strobe_oe,
  input  wire logic [19:0] local_address_lines,
  input  wire logic [15:0] local_data_out,
  input  wire logic        upper_byte_enable_n,
  input  wire logic        hold_request,
  // Behaviour knobs
  input  wire logic [3:0]  rdy_dly,
  input  wire logic        grant_en,
  // Answers and captures
  output logic [15:0]      local_data_in,
  output logic             local_ready_n,
  output logic             hold_grant,
  output logic [19:0]      cap_addr,
  output logic [15:0]      cap_data,
  output logic             cap_ube_n,
  output var int           n_cyc
);
  logic       act;
  logic       act_q;
  logic       local_bus_clock_out_q;
  logic [3:0] n_rise;
  logic [1:0] gnt_q;

  assign act = strobe_oe && !(write_strobe_n && read_strobe_n);

  initial begin
    {act_q, local_bus_clock_out_q, hold_grant, local_ready_n} = 4'h1;
    {n_rise, gnt_q, n_cyc} = '0;
    local_data_in = 16'h0F0F;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    local_bus_clock_out_q <= local_bus_clock_out;
    act_q  <= act;
    // Idle lines toggle so a stale value never passes for an answer
    local_data_in <= (act && !read_strobe_n) ? 16'hA55A : ~local_data_in;
    if (!act)
      n_rise <= 4'h0;
    else if (local_bus_clock_out && !local_bus_clock_out_q && n_rise != 4'hF)
      n_rise <= n_rise + 4'h1;
    // Count F never answers, to force the bridge into its timeout
    local_ready_n <= !(act && rdy_dly != 4'hF && n_rise >= rdy_dly);
    if (act) begin
      cap_addr  <= local_address_lines;
      cap_data  <= local_data_out;
      cap_ube_n <= upper_byte_enable_n;
    end
    if (act && !act_q)
      n_cyc <= n_cyc + 1;
    gnt_q      <= {gnt_q[0], hold_request && grant_en};
    hold_grant <= gnt_q[1];
  end
endmodule : plbb_local_model
`default_nettype wire

/* plbb_bridge_tb.sv */
// Purpose: Self-checking bench for the host-to-local bus bridge.
// Assumes: Both strobe styles; partner in plbb_local_model.
// Notes:   Each scenario task drives and judges its own traffic.
`timescale 1ns/1ps
`default_nettype none
module plbb_bridge_tb;
  // Stimulus
  logic        clk = 1'b0, srst = 1'b1, bus_role_select = 1'b0;
  logic        strobe_style_select = 1'b0, local_select_n = 1'b1;
  logic        local_bus_error_clear = 1'b0, local_interrupt_clear = 1'b0;
  logic        host_req = 1'b0, host_write = 1'b0, local_irq_n_in = 1'b1;
  logic        grant_en = 1'b0;
  logic [15:0] bridge_control_reg = 16'h0001;
  logic [19:0] host_addr = 20'hABC00;
  logic [31:0] host_wdata = 32'h44332211;
  logic [3:0]  pci_byte_enables_n = 4'hF, rdy_dly = 4'h1;
  // Observed
  logic        local_bus_error_flag, local_interrupt_flag, host_done;
  logic        host_abort, host_retry, local_address_oe, local_data_oe;
  logic        write_strobe_n, read_strobe_n, strobe_oe, upper_byte_oe;
  logic        upper_byte_enable_n, local_bus_clock_out, local_clock_oe;
  logic        hold_request, hold_oe, bus_ownership_ack_n, ownership_oe;
  logic        local_ready_n, hold_grant, local_irq_oe, cap_ube_n;
  logic        local_irq_n_out;
  logic [31:0] host_rdata;
  logic [19:0] local_address_lines, cap_addr;
  logic [15:0] local_data_in, local_data_out, cap_data;
  int          n_mismatch = 0, checks_done = 0, rd_drive = 0;
  int          n_cyc, code, lat, k, base;
  longint      t0;

  always #2.5 clk = ~clk;

  plbb_bridge i_plbb_bridge (
    .clk, .srst, .bus_role_select, .strobe_style_select, .bridge_control_reg,
    .local_bus_error_clear, .local_bus_error_flag, .local_interrupt_clear,
    .local_interrupt_flag, .host_req, .host_write, .host_addr, .host_wdata,
    .pci_byte_enables_n, .host_done, .host_abort, .host_retry, .host_rdata,
    .local_address_lines, .local_address_oe, .local_data_in, .local_data_out,
    .local_data_oe, .write_strobe_n, .read_strobe_n, .strobe_oe,
    .upper_byte_enable_n, .upper_byte_oe, .local_bus_clock_out,
    .local_clock_oe, .hold_request, .hold_oe, .bus_ownership_ack_n,
    .ownership_oe, .local_ready_n, .hold_grant, .local_irq_n_in,
    .local_irq_n_out, .local_irq_oe, .local_select_n);

  plbb_local_model i_plbb_local_model (
    .clk, .local_bus_clock_out, .write_strobe_n, .read_strobe_n, .strobe_oe,
    .local_address_lines, .local_data_out, .upper_byte_enable_n,
    .hold_request, .rdy_dly, .grant_en, .local_data_in, .local_ready_n,
    .hold_grant, .cap_addr, .cap_data, .cap_ube_n, .n_cyc);

  // Data lines must stay released while the bridge reads, in either style
  always @(negedge clk)
    if (strobe_oe && local_data_oe === 1'b1 && !read_strobe_n &&
        (!strobe_style_select || write_strobe_n)) rd_drive++;

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, lo, hi, input string what);
    checks_done++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("mismatch at %0t: %s took %0d", $time, what, got);
    end
  endtask : chk_rng

  task automatic hang(input string what);
    n_mismatch++;
    $display("mismatch at %0t: %s never came", $time, what);
    report_and_stop();
  endtask : hang

  task automatic set_ctrl(input logic [15:0] v);
    @(posedge clk);
    bridge_control_reg <= v;
    @(posedge clk);
  endtask : set_ctrl

  // One host access; code 1 done, 2 abort, 3 retry, 0 none
  task automatic host_op(input logic wr, input logic [3:0] be, input bit idle);
    @(posedge clk);
    host_req           <= 1'b1;
    host_write         <= wr;
    pci_byte_enables_n <= be;
    @(posedge clk);
    host_req <= 1'b0;
    code = 0;
    for (lat = 1; lat < 300 && code == 0; lat++) begin
      #1;
      if (host_done === 1'b1) code = 1;
      else if (host_abort === 1'b1) code = 2;
      else if (host_retry === 1'b1) code = 3;
      else @(posedge clk);
    end
    if (code == 0 && !idle) hang("answer");
  endtask : host_op

  task automatic wait_ack(input logic lvl);
    for (lat = 0; bus_ownership_ack_n !== lvl; lat++) begin
      @(posedge clk);
      #1;
      if (lat > 400) hang("ownership");
    end
  endtask : wait_ack

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_narrow;
    set_ctrl(16'h0049);
    for (k = 0; k < 4; k++) begin
      host_op(1'b1, ~(4'h1 << k), 1'b0);
      chk(code, 1, "code");
      chk(cap_addr, {host_addr[19:2], k[1:0]}, "addr");
      chk(cap_data[7:0], host_wdata[8*k +: 8], "byte");
      chk(cap_ube_n, 1'b1, "ube");
    end
    host_op(1'b0, 4'hE, 1'b0);
    chk(host_rdata, 32'h5A5A5A5A, "rdata");
    base = n_cyc;
    host_op(1'b1, 4'hC, 1'b0);
    chk(code, 2, "abort");
    host_op(1'b1, 4'hF, 1'b1);
    chk(code, 0, "none");
    chk(n_cyc, base, "cycles");
  endtask : t_narrow

  task automatic t_wide;
    logic [23:0] bes = 24'h37BCDE;
    logic [11:0] ax = 12'hB84;
    logic [95:0] dx = 96'h4433_4444_3333_2211_2222_1111;
    logic [95:0] mx = 96'hFFFF_FF00_00FF_FFFF_FF00_00FF;
    logic [5:0]  ux = 6'h09;
    set_ctrl(16'h0009);
    for (k = 0; k < 6; k++) begin
      host_op(1'b1, bes[4*k +: 4], 1'b0);
      chk(code, 1, "code");
      chk(cap_addr, {host_addr[19:2], ax[2*k +: 2]}, "addr");
      chk(cap_data & mx[16*k +: 16], dx[16*k +: 16] & mx[16*k +: 16],
          "data");
      chk(cap_ube_n, ux[k], "ube");
    end
    host_op(1'b0, 4'hC, 1'b0);
    chk(host_rdata, 32'hA55AA55A, "rdata");
    base = n_cyc;
    for (k = 0; k < 3; k++) begin
      host_op(1'b1, 4'(12'h90A >> (4 * k)), 1'b0);
      chk(code, 2, "abort");
    end
    host_op(1'b0, 4'hF, 1'b1);
    chk(code, 0, "none");
    chk(n_cyc, base, "cycles");
  endtask : t_wide

  task automatic t_len;
    set_ctrl(16'h0005);
    host_op(1'b1, 4'hC, 1'b0);
    chk_rng(lat, 6, 22, "len 1");
    set_ctrl(16'h002D);
    host_op(1'b1, 4'hC, 1'b0);
    chk_rng(lat, 66, 82, "len 11");
    set_ctrl(16'h0001);
    rdy_dly <= 4'h3;
    host_op(1'b0, 4'hC, 1'b0);
    chk(code, 1, "ready");
    rdy_dly <= 4'hF;
    host_op(1'b0, 4'hC, 1'b0);
    chk(code, 3, "timeout");
    chk_rng(lat, 54, 80, "timeout");
    repeat (2) @(posedge clk);
    #1;
    chk(local_bus_error_flag, 1'b1, "err");
    @(posedge clk);
    local_bus_error_clear <= 1'b1;
    @(posedge clk);
    local_bus_error_clear <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(local_bus_error_flag, 1'b0, "err clr");
    rdy_dly <= 4'h1;
  endtask : t_len

  task automatic t_arb;
    set_ctrl(16'h000B);
    repeat (4) @(posedge clk);
    base = n_cyc;
    host_op(1'b1, 4'hC, 1'b0);
    chk(code, 3, "retry");
    chk({local_address_oe, local_data_oe, strobe_oe, upper_byte_oe}, 4'h0,
        "float");
    repeat (40) @(posedge clk);
    #1;
    chk(hold_request, 1'b1, "hold");
    chk(bus_ownership_ack_n, 1'b1, "early ack");
    chk(n_cyc, base, "cycles");
    @(posedge clk);
    grant_en <= 1'b1;
    wait_ack(1'b0);
    t0 = $time;
    host_op(1'b1, 4'hC, 1'b0);
    chk(code, 1, "owned");
    // Late in the seize window fewer than sixteen clocks remain
    repeat (100) @(posedge clk);
    base = n_cyc;
    host_op(1'b1, 4'hC, 1'b0);
    chk(code, 3, "seize margin");
    chk(bus_ownership_ack_n, 1'b0, "still owned");
    chk(n_cyc, base, "cycles");
    wait_ack(1'b1);
    chk_rng(int'(($time - t0) / 5), 180, 200, "seize");
    set_ctrl(16'h0001);
    grant_en <= 1'b0;
  endtask : t_arb

  task automatic t_irq;
    @(posedge clk);
    local_irq_n_in <= 1'b0;
    repeat (3) @(posedge clk);
    local_irq_n_in <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(local_interrupt_flag, 1'b1, "irq");
    @(posedge clk);
    local_interrupt_clear <= 1'b1;
    @(posedge clk);
    local_interrupt_clear <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(local_interrupt_flag, 1'b0, "irq clr");
  endtask : t_irq

  task automatic t_style;
    @(posedge clk);
    strobe_style_select <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(hold_request, 1'b1, "request idle");
    host_op(1'b0, 4'hD, 1'b0);
    chk(host_rdata, 32'hA5A5A5A5, "rw read");
    host_op(1'b1, 4'h3, 1'b0);
    chk(cap_data, 16'h4433, "rw write");
    @(posedge clk);
    strobe_style_select <= 1'b0;
  endtask : t_style

  task automatic t_config;
    @(posedge clk);
    bus_role_select <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk({local_irq_n_out, local_irq_oe, local_clock_oe, hold_oe, ownership_oe,
         upper_byte_oe, local_address_oe, strobe_oe}, 8'hC0, "cfg");
    base = n_cyc;
    host_op(1'b1, 4'hC, 1'b1);
    chk(code, 0, "cfg access");
    chk(n_cyc, base, "cycles");
    @(posedge clk);
    bus_role_select <= 1'b0;
  endtask : t_config

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(hold_request, 1'b0, "hold");
    chk({local_irq_oe, local_clock_oe, local_address_oe}, 3'h3,
        "bridge oe");
    t_narrow();
    t_wide();
    t_len();
    t_arb();
    t_irq();
    t_style();
    t_config();
    chk(rd_drive, 0, "read drive");
    report_and_stop();
  end
endmodule : plbb_bridge_tb
`default_nettype wire
